// *** pkg/gpcmd_pkg.sv ***
// Package for the instrument bus command handler: command codes, register map, constants.
// Assumes one 50 MHz system clock and an Avalon-MM register master.
package gpcmd_pkg;

    // Interface command bytes (ATN true, bit 7 ignored)
    localparam logic [6:0] CMD_NUL = 7'h00;
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3F;
    localparam logic [6:0] CMD_UNT = 7'h5F;
    localparam logic [1:0] GRP_LAD = 2'h1;
    localparam logic [1:0] GRP_TAD = 2'h2;

    // Bus address range and fallback
    localparam logic [4:0] ADDR_MAX     = 5'h1E;
    localparam logic [4:0] ADDR_DEFAULT = 5'h03;

    // Register byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RXDATA = 4'h8;
    localparam logic [3:0] REG_TXDATA = 4'hC;

    // Control register fields
    localparam int CTRL_ADDR_LSB  = 0;
    localparam int CTRL_TONLY     = 8;
    localparam int CTRL_SPSTAT_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

    // Status register fields
    localparam int ST_LSN = 0;
    localparam int ST_TLK = 1;
    localparam int ST_RMT = 2;
    localparam int ST_LLO = 3;
    localparam int ST_SPM = 4;
    localparam int ST_RXV = 5;
    localparam int ST_EOM = 6;
    localparam int ST_TXF = 7;

    // Bus byte carrier
    typedef struct packed {
        logic [7:0] data;
        logic       atn;
        logic       eoi;
    } gpcmd_byte_t;

    // Handshake states, one-hot
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_TAKE = 3'b010,
        HS_DONE = 3'b100
    } gpcmd_hs_t;

endpackage : gpcmd_pkg

// *** hdl/gpcmd_acceptor.sv ***
// Byte acceptor: listener side of the three-wire handshake.
// Assumes bus lines already synchronous to clk_sys; DAV from talker, NRFD/NDAC open drain.
module gpcmd_acceptor
    import gpcmd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        ready,
    input  wire logic        dav_n,
    input  wire gpcmd_byte_t bus_in,
    output logic             nrfd_oe,
    output logic             ndac_oe,
    output logic             byte_valid,
    output gpcmd_byte_t      byte_out
);

    gpcmd_hs_t state;
    gpcmd_hs_t next_state;

    ////////////////////////////////////////////////////////////////////////
    // Handshake sequence; holding NRFD low until ready throttles the talker
    always_comb begin
        next_state = state;
        case (state)
            HS_IDLE: if (enable && ready && !dav_n) next_state = HS_TAKE;
            HS_TAKE: next_state = HS_DONE;
            HS_DONE: if (dav_n || !enable) next_state = HS_IDLE;
            default: next_state = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) state <= HS_IDLE;
        else state <= next_state;
    end

    // Latch byte while DAV is low
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            byte_out   <= '0;
            byte_valid <= 1'b0;
        end else begin
            byte_valid <= (state == HS_IDLE) && (next_state == HS_TAKE);
            if ((state == HS_IDLE) && (next_state == HS_TAKE)) byte_out <= bus_in;
        end
    end

    // Open drain: oe low means drive low; NRFD released when disabled, or when ready and idle; NDAC released when disabled or done
    assign nrfd_oe = !(enable && !(ready && state == HS_IDLE));
    assign ndac_oe = !(enable && state != HS_DONE);

    a_nrfd_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enable && state != HS_IDLE) |-> !nrfd_oe)
        else $error("NRFD released while not ready");

endmodule : gpcmd_acceptor

// *** hdl/gpcmd_handler.sv ***
// Instrument bus interface command handler: address, remote, lockout, poll and clear logic.
// Assumes bus pins synchronous to clk_sys and an Avalon-MM master for the registers.
//
// Overview of operation
// - With controller, both talk and listen.
// - Talk-only mode: send, never listen.
// - Commands are coded bytes, not text.
// - ATN true: byte is interface command.
// - DCL clears errors, commands, both buffers.
// - EOI with data marks final byte.
// - GET when listening restarts measurement.
// - GTL when listening: local, lockout kept.
// - IFC drops talker, listener; idle.
// - Matching listen address makes listener.
// - Matching talk address makes talker.
// - LLO in remote locks front keys.
// - REN false: local, lockout cleared.
// - Null command changes nothing.
// - REN plus listen address enters remote.
// - SDC clears only when listener.
// - SPE: talker sends status byte.
// - SPD: talker resumes measurement data.
// - UNL drops listener role.
// - UNT or other talk address drops talker.
// - Address 0 to 30, else 3; a register write above 30 is ignored and keeps the old address.
module gpcmd_handler
    import gpcmd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    // Stored address from nonvolatile memory
    input  wire logic [4:0]  nv_addr,
    input  wire logic        nv_addr_ok,
    // Bus pins
    input  wire logic        atn_n,
    input  wire logic        ifc_n,
    input  wire logic        ren_n,
    input  wire logic        eoi_n_in,
    input  wire logic [7:0]  dio_n_in,
    input  wire logic        dav_n_in,
    input  wire logic        nrfd_n_in,
    input  wire logic        ndac_n_in,
    output logic [7:0]       dio_oe,
    output logic             dav_oe,
    output logic             eoi_oe,
    output logic             nrfd_oe,
    output logic             ndac_oe,
    // Measurement core and front panel
    output logic             meas_trigger,
    output logic             dev_clear,
    output logic             remote,
    output logic             lockout,
    output logic             listener,
    output logic             talker,
    input  wire logic        local_key
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_eom;
    logic [7:0]  tx_data;
    logic        tx_eoi;
    logic        tx_full;
    logic        serial_poll;
    logic        addr_valid;
    logic [4:0]  my_addr;
    logic        tx_busy;
    logic [1:0]  tx_phase;

    // Control decode
    wire         talk_only  = ctrl[CTRL_TONLY];
    wire [4:0]   cfg_addr   = ctrl[CTRL_ADDR_LSB +: 5];
    wire [7:0]   poll_stat  = ctrl[CTRL_SPSTAT_LSB +: 8];

    ////////////////////////////////////////////////////////////////////////
    // Address capture after reset release; a bad or out-of-range store falls back
    wire [4:0] boot_addr = (nv_addr_ok && nv_addr <= ADDR_MAX) ? nv_addr : ADDR_DEFAULT;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_valid <= 1'b0;
            my_addr    <= ADDR_DEFAULT;
        end else if (!addr_valid) begin
            addr_valid <= 1'b1;
            my_addr    <= boot_addr;
        end else if (avs_write && !avs_waitrequest && avs_address == REG_CTRL
                     && avs_byteenable[0] && avs_writedata[4:0] <= ADDR_MAX) begin
            my_addr    <= avs_writedata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte acceptor; only a listener or a command phase takes bytes
    gpcmd_byte_t bus_byte;
    gpcmd_byte_t rx_byte;
    logic        rx_strobe;
    wire         atn        = !atn_n;
    wire         take_en    = !talk_only && (atn || (listener && !rx_valid));

    assign bus_byte.data = ~dio_n_in;
    assign bus_byte.atn  = atn;
    assign bus_byte.eoi  = !eoi_n_in;

    gpcmd_acceptor u_acceptor (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .enable     (take_en),
        .ready      (1'b1),
        .dav_n      (dav_n_in),
        .bus_in     (bus_byte),
        .nrfd_oe    (nrfd_oe),
        .ndac_oe    (ndac_oe),
        .byte_valid (rx_strobe),
        .byte_out   (rx_byte)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command decode; bit 7 is parity and ignored
    wire       is_cmd   = rx_strobe && rx_byte.atn;
    wire       is_data  = rx_strobe && !rx_byte.atn && listener;
    wire [6:0] cmd      = rx_byte.data[6:0];
    wire [4:0] cmd_addr = rx_byte.data[4:0];
    wire       c_mla    = is_cmd && cmd[6:5] == GRP_LAD && cmd_addr == my_addr;
    wire       c_mta    = is_cmd && cmd[6:5] == GRP_TAD && cmd_addr == my_addr;
    wire       c_otad   = is_cmd && cmd[6:5] == GRP_TAD && cmd_addr != my_addr;
    wire       c_unl    = is_cmd && cmd == CMD_UNL;
    wire       c_dcl    = is_cmd && cmd == CMD_DCL;
    wire       c_sdc    = is_cmd && cmd == CMD_SDC && listener;
    wire       c_get    = is_cmd && cmd == CMD_GET && listener;
    wire       c_gtl    = is_cmd && cmd == CMD_GTL && listener;
    wire       c_llo    = is_cmd && cmd == CMD_LLO;
    wire       c_spe    = is_cmd && cmd == CMD_SPE;
    wire       c_spd    = is_cmd && cmd == CMD_SPD;
    wire       ifc      = !ifc_n;
    wire       ren      = !ren_n;
    wire       sw_clear = avs_write && !avs_waitrequest && avs_address == REG_STATUS;
    wire       do_clear = c_dcl || c_sdc;

    ////////////////////////////////////////////////////////////////////////
    // Addressing state; IFC wins over everything, talk-only forces talker
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            listener <= 1'b0;
            talker   <= 1'b0;
        end else if (ifc) begin
            listener <= 1'b0;
            talker   <= 1'b0;
        end else if (talk_only) begin
            listener <= 1'b0;
            talker   <= 1'b1;
        end else begin
            if (c_mla) listener <= 1'b1;
            else if (c_unl) listener <= 1'b0;
            if (c_mta) talker <= 1'b1;
            else if (c_otad || (is_cmd && cmd == CMD_UNT)) talker <= 1'b0;
        end
    end

    // NUL and unlisted codes fall through every decode above untouched
    a_nul_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_cmd && cmd == CMD_NUL && !ifc && !talk_only) |=> $stable(listener)
        && $stable(talker) && $stable(serial_poll))
        else $error("null command changed state");

    ////////////////////////////////////////////////////////////////////////
    // Remote and lockout; REN false clears both, GTL keeps lockout
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            remote  <= 1'b0;
            lockout <= 1'b0;
        end else if (!ren) begin
            remote  <= 1'b0;
            lockout <= 1'b0;
        end else begin
            if (c_mla) remote <= 1'b1;
            else if (c_gtl) remote <= 1'b0;
            else if (local_key && !lockout) remote <= 1'b0;
            if (c_llo && remote) lockout <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial poll mode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) serial_poll <= 1'b0;
        else if (ifc || c_spd) serial_poll <= 1'b0;
        else if (c_spe) serial_poll <= 1'b1;
    end

    // Measurement core pulses
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meas_trigger <= 1'b0;
            dev_clear    <= 1'b0;
        end else begin
            meas_trigger <= c_get;
            dev_clear    <= do_clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive holding byte; a new byte wins over a software clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_data  <= '0;
            rx_valid <= 1'b0;
            rx_eom   <= 1'b0;
        end else if (do_clear) begin
            rx_valid <= 1'b0;
            rx_eom   <= 1'b0;
        end else if (is_data) begin
            rx_data  <= rx_byte.data;
            rx_valid <= 1'b1;
            rx_eom   <= rx_byte.eoi;
        end else if (avs_read && !avs_waitrequest && avs_address == REG_RXDATA) begin
            rx_valid <= 1'b0;
        end else if (sw_clear && avs_writedata[ST_EOM]) begin
            rx_eom   <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Talker source: one output byte, with the three-wire source handshake
    wire tx_go   = talker && !atn && !ifc && (serial_poll || tx_full) && !tx_busy;
    wire tx_wr   = avs_write && !avs_waitrequest && avs_address == REG_TXDATA;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_data  <= '0;
            tx_eoi   <= 1'b0;
            tx_full  <= 1'b0;
            tx_busy  <= 1'b0;
            tx_phase <= 2'h0;
        end else if (do_clear || ifc || atn) begin
            // Host may fill the byte during a command phase; only a clear drops it
            if (tx_wr && !tx_full && !do_clear) begin
                tx_data <= avs_writedata[7:0];
                tx_eoi  <= avs_writedata[8];
            end
            tx_full  <= do_clear ? 1'b0 : (tx_full || tx_wr);
            tx_busy  <= 1'b0;
            tx_phase <= 2'h0;
        end else begin
            if (tx_wr && !tx_full) begin
                tx_data <= avs_writedata[7:0];
                tx_eoi  <= avs_writedata[8];
                tx_full <= 1'b1;
            end
            if (tx_go && !nrfd_n_in == 1'b0) begin
                tx_busy  <= 1'b1;
                tx_phase <= 2'h1;
            end else if (tx_busy && tx_phase == 2'h1 && ndac_n_in) begin
                tx_phase <= 2'h2;
            end else if (tx_busy && tx_phase == 2'h2) begin
                tx_busy  <= 1'b0;
                tx_phase <= 2'h0;
                if (!serial_poll) tx_full <= 1'b0;
            end
        end
    end

    // Pins: status byte replaces data while polled
    wire [7:0] tx_byte = serial_poll ? poll_stat : tx_data;
    assign dio_oe = (tx_busy) ? tx_byte ^ 8'hFF : 8'hFF;
    assign dav_oe = !(tx_busy && tx_phase == 2'h1);
    assign eoi_oe = !(tx_busy && tx_eoi && !serial_poll);

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: fixed one wait cycle for every access
    logic ack;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) ack <= 1'b0;
        else ack <= (avs_read || avs_write) && !ack;
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    wire [31:0] status_word = {24'h0, tx_full, rx_eom, rx_valid, serial_poll,
                               lockout, remote, talker, listener};
    wire        addr_known  = avs_address == REG_CTRL || avs_address == REG_STATUS
                              || avs_address == REG_RXDATA || avs_address == REG_TXDATA;
    wire [31:0] rd_mux = (avs_address == REG_CTRL)   ? {ctrl[31:5], my_addr} :
                         (avs_address == REG_STATUS) ? status_word :
                         (avs_address == REG_RXDATA) ? {23'h0, rx_eom, rx_data} : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl         <= CTRL_RESET;
            avs_readdata <= '0;
            avs_response <= 2'h0;
        end else begin
            if (avs_write && !ack && avs_address == REG_CTRL) begin
                for (int i = 0; i < 4; i++) begin
                    if (avs_byteenable[i]) ctrl[i*8 +: 8] <= avs_writedata[i*8 +: 8];
                end
            end
            if ((avs_read || avs_write) && !ack) begin
                avs_readdata <= rd_mux;
                avs_response <= addr_known ? 2'h0 : 2'h2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_ifc_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ifc |=> (!listener && !talker && dav_oe))
        else $error("IFC left device addressed");
    a_tonly_nolisten: assert property (@(posedge clk_sys) disable iff (!rst_n)
        talk_only |=> !listener)
        else $error("listener in talk-only mode");
    a_mla_listen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_mla && !ifc && !talk_only) |=> listener)
        else $error("my listen address ignored");
    a_mta_talk: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_mta && !ifc && !talk_only) |=> talker)
        else $error("my talk address ignored");
    a_other_tad: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_otad && !talk_only) |=> !talker)
        else $error("other talk address kept talker");
    a_unl_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_unl && !c_mla && !talk_only) |=> !listener)
        else $error("UNL kept listener");
    a_ren_local: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ren |=> (!remote && !lockout))
        else $error("REN false kept remote");
    a_gtl_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_gtl && ren && !c_mla) |=> (!remote && lockout == $past(lockout)))
        else $error("GTL wrong");
    a_get_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        c_get |=> meas_trigger ##1 !meas_trigger)
        else $error("GET trigger missing");
    a_sdc_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_cmd && cmd == CMD_SDC && !listener) |=> !dev_clear)
        else $error("SDC acted while not listener");
    a_dcl_flush: assert property (@(posedge clk_sys) disable iff (!rst_n)
        c_dcl |=> (dev_clear && !rx_valid && !tx_full))
        else $error("DCL did not flush");
    a_eoi_mark: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_data && !do_clear) |=> rx_eom == $past(rx_byte.eoi))
        else $error("EOI not recorded");
    a_llo_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_llo && remote && ren) |=> lockout)
        else $error("LLO ignored in remote");
    a_spe_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_spe && !ifc) |=> serial_poll)
        else $error("SPE ignored");
    a_spd_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        c_spd |=> !serial_poll)
        else $error("SPD ignored");
    a_ren_remote: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (c_mla && ren) |=> remote)
        else $error("remote not entered");
    a_addr_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        addr_valid |-> my_addr <= ADDR_MAX)
        else $error("bus address out of range");
    a_cmd_noData: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (is_cmd && !do_clear && !is_data) |=> $stable(rx_valid) || !rx_valid)
        else $error("command stored as data");

endmodule : gpcmd_handler

// *** bench/gpcmd_ctrl_model.sv ***
// Bus controller model: sends command and data bytes, takes talker bytes.
// Assumes the bench makes each line the AND of all parties' drives.
module gpcmd_ctrl_model (
    input  wire logic       clk_sys,
    input  wire logic       dav_w,
    input  wire logic       nrfd_w,
    input  wire logic       ndac_w,
    input  wire logic       eoi_w,
    input  wire logic [7:0] dio_w,
    output logic            atn_n,
    output logic            eoi_n,
    output logic [7:0]      dio_n,
    output logic            dav_n,
    output logic            nrfd_n,
    output logic            ndac_n,
    output logic            tmo
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [2:0] hs = {ndac_w, nrfd_w, dav_w};
    // All lines released at start
    initial {atn_n, eoi_n, dio_n, dav_n, nrfd_n, ndac_n, tmo} = {13'h1FFF, 1'b0};
    ////////////////////////////////////////////////////////////////////////
    // Bounded wait; a stuck handshake raises tmo
    task automatic wt(input int k, input logic v);
        int n;
        n = 0;
        while (hs[k] !== v && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 200) tmo <= 1'b1;
    endtask : wt
    // Source side; freed data lines float high
    task automatic send(input logic a, input logic e, input logic [7:0] d);
        atn_n <= !a; // ATN true: coded command byte
        @(posedge clk_sys);
        wt(1, 1'b1);
        dio_n <= ~d;
        eoi_n <= !e;
        dav_n <= 1'b0;
        @(posedge clk_sys);
        wt(2, 1'b1);
        {dav_n, eoi_n, dio_n} <= 10'h3FF;
        @(posedge clk_sys);
    endtask : send
    // Listen-always acceptor, no addressing needed
    task automatic recv(output logic [8:0] q);
        atn_n <= 1'b1;
        ndac_n <= 1'b0;
        @(posedge clk_sys);
        wt(0, 1'b0);
        q = {!eoi_w, ~dio_w};
        nrfd_n <= 1'b0;
        ndac_n <= 1'b1;
        @(posedge clk_sys);
        wt(0, 1'b1);
        nrfd_n <= 1'b1;
    endtask : recv
endmodule : gpcmd_ctrl_model

// *** bench/gpcmd_handler_test.sv ***
// Bench for the command handler: Avalon tasks and a controller model.
// Assumes pull-ups on every bus line.
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module gpcmd_handler_test
    import gpcmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] MY = 5'h05;
    logic        clk_sys, rst_n, avs_read, avs_write, nv_addr_ok, ifc_n, ren_n, local_key;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [4:0]  nv_addr;
    logic [1:0]  avs_response, rsp;
    logic [7:0]  dio_oe, c_dio;
    logic        avs_waitrequest, dav_oe, eoi_oe, nrfd_oe, ndac_oe, meas_trigger, dev_clear;
    logic        remote, lockout, listener, talker, c_atn, c_eoi, c_dav, c_nrfd, c_ndac, tmo;
    logic [8:0]  q;
    int          mismatches = 0, cmp_count = 0, trig_cnt = 0, clr_cnt = 0;
    // Open-drain lines low when any party pulls
    wire logic [7:0] dio_w = c_dio & dio_oe;
    wire logic       dav_w = c_dav & dav_oe;
    wire logic       eoi_w = c_eoi & eoi_oe;
    wire logic       nrfd_w = c_nrfd & nrfd_oe;
    wire logic       ndac_w = c_ndac & ndac_oe;
    wire logic [3:0] st = {talker, listener, remote, lockout};
    gpcmd_handler u_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
        .nv_addr, .nv_addr_ok, .atn_n(c_atn), .ifc_n, .ren_n, .eoi_n_in(eoi_w),
        .dio_n_in(dio_w), .dav_n_in(dav_w), .nrfd_n_in(nrfd_w), .ndac_n_in(ndac_w),
        .dio_oe, .dav_oe, .eoi_oe, .nrfd_oe, .ndac_oe, .meas_trigger, .dev_clear,
        .remote, .lockout, .listener, .talker, .local_key);
    gpcmd_ctrl_model u_ctl (.clk_sys, .dav_w, .nrfd_w, .ndac_w, .eoi_w, .dio_w,
        .atn_n(c_atn), .eoi_n(c_eoi), .dio_n(c_dio), .dav_n(c_dav), .nrfd_n(c_nrfd),
        .ndac_n(c_ndac), .tmo);
    ////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Pulse tally and hang guards
    always @(posedge clk_sys) begin
        trig_cnt <= trig_cnt + int'(meas_trigger === 1'b1);
        clr_cnt <= clr_cnt + int'(dev_clear === 1'b1);
        if (tmo === 1'b1) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    // Avalon access; holds until waitrequest seen low
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        rsp = avs_response;
        {avs_write, avs_read} <= 2'b00;
        @(posedge clk_sys);
        if (n >= 50) begin
            mismatches++;
            final_report();
        end
    endtask : av
    task automatic cmd(input logic [6:0] c);
        u_ctl.send(1'b1, 1'b0, {1'b0, c});
    endtask : cmd
    task automatic reboot(input logic ok);
        {rst_n, nv_addr_ok} <= {1'b0, ok};
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        av(1'b0, REG_CTRL, 32'h0);
    endtask : reboot
    // Main sequence
    initial begin
        {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {avs_byteenable, nv_addr, nv_addr_ok, ifc_n, ren_n, local_key} = {4'hF, MY, 4'b1100};
        @(posedge clk_sys);
        reboot(1'b1);
        `CHK(rd[4:0], MY)
        cmd({GRP_LAD, MY});
        `CHK(st, 4'b0110)
        cmd(CMD_NUL);
        `CHK(st, 4'b0110)
        cmd(CMD_LLO);
        local_key <= 1'b1;
        repeat (2) @(posedge clk_sys);
        local_key <= 1'b0;
        u_ctl.send(1'b0, 1'b0, 8'h3F);
        `CHK(st, 4'b0111)
        cmd(CMD_GTL);
        `CHK(st, 4'b0101)
        cmd(CMD_GET);
        cmd(CMD_SDC);
        cmd(CMD_DCL);
        av(1'b0, REG_STATUS, 32'h0);
        `CHK({trig_cnt, clr_cnt, rd[ST_RXV]}, {32'd1, 32'd2, 1'b0})
        cmd(CMD_UNL);
        cmd(CMD_GET);
        cmd(CMD_SDC);
        `CHK({st, trig_cnt, clr_cnt}, {4'b0001, 32'd1, 32'd2})
        $display("test listen done");
        cmd({GRP_TAD, MY});
        `CHK(talker, 1'b1)
        cmd({GRP_TAD, 5'h06});
        `CHK(talker, 1'b0)
        cmd({GRP_TAD, MY});
        cmd(CMD_UNT);
        `CHK(talker, 1'b0)
        cmd({GRP_LAD, MY});
        u_ctl.send(1'b0, 1'b1, 8'hA5);
        av(1'b0, REG_RXDATA, 32'h0);
        `CHK(rd[8:0], 9'h1A5)
        $display("test talk done");
        av(1'b1, REG_CTRL, 32'h005A_0005);
        cmd({GRP_TAD, MY});
        cmd(CMD_SPE);
        u_ctl.recv(q);
        `CHK(q[7:0], 8'h5A)
        cmd(CMD_SPD);
        av(1'b1, REG_TXDATA, 32'h1C3);
        u_ctl.recv(q);
        `CHK(q, 9'h1C3)
        $display("test poll done");
        ren_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK({remote, lockout}, 2'b00)
        ifc_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ifc_n <= 1'b1;
        `CHK({talker, listener}, 2'b00)
        av(1'b0, 4'h2, 32'h0);
        `CHK({rsp, rd}, {2'b10, 32'h0})
        av(1'b1, REG_CTRL, 32'h0000_0105);
        cmd({GRP_LAD, MY});
        av(1'b1, REG_TXDATA, 32'h07E);
        u_ctl.recv(q);
        `CHK({talker, listener, q[7:0]}, {2'b10, 8'h7E})
        $display("test clear and talk-only done");
        av(1'b1, REG_CTRL, 32'h1F);
        av(1'b0, REG_CTRL, 32'h0);
        `CHK(rd[4:0], MY)
        reboot(1'b0);
        `CHK(rd[4:0], ADDR_DEFAULT)
        $display("test address done");
        final_report();
    end
endmodule : gpcmd_handler_test
